// ==== rtl/rfl_pkg.sv ====
// constants and register layout for the cable reflectometry capture block
package rfl_pkg;
  // register addresses
  localparam logic [4:0]  ADDR_CONTROL   = 5'h16;
  localparam logic [4:0]  ADDR_WINDOW    = 5'h17;
  localparam logic [4:0]  ADDR_PEAK      = 5'h18;
  localparam logic [4:0]  ADDR_THRESHOLD = 5'h19;
  // control register field positions
  localparam int CTL_FAST_BIT   = 14;
  localparam int CTL_TXCH_BIT   = 13;
  localparam int CTL_RXCH_BIT   = 12;
  localparam int CTL_LAUNCH_BIT = 11;
  localparam int CTL_WIDTH_HI   = 10;
  localparam int CTL_WIDTH_LO   = 8;
  localparam int CTL_MIN_BIT    = 7;
  localparam int CTL_THR_HI     = 5;
  // window and result field positions
  localparam int WIN_START_LO   = 8;
  localparam int PEAK_VAL_LO    = 8;
  localparam int THR_MET_BIT    = 8;
  // reset values
  localparam logic [5:0]  THRESHOLD_RST  = 6'h20;
  localparam logic [7:0]  WIN_START_RST  = 8'h00;
  localparam logic [7:0]  WIN_STOP_RST   = 8'hFF;
  localparam logic [2:0]  WIDTH_RST      = 3'h0;
  // timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int STEP_NS        = 8;
  localparam int LINK_STEP_NS   = 50;
  localparam int LINK_STEP_CYC  = (LINK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // capture sequencer states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_CAPTURE = 3'b010,
    ST_DONE    = 3'b100
  } rfl_state_t;
endpackage : rfl_pkg

// ==== rtl/rfl_track.sv ====
// peak and threshold tracker for one reflectometry capture
`timescale 1ns/1ps
module rfl_track
  import rfl_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       sample_en,
  input  wire logic [5:0] sample,
  input  wire logic [7:0] sample_time,
  input  wire logic       min_mode,
  input  wire logic [5:0] threshold,
  output logic      [5:0] peak_value_q,
  output logic      [7:0] peak_time_q,
  output logic            threshold_met_q,
  output logic      [7:0] threshold_time_q
);
  logic seen_q;   // at least one sample taken this capture
  logic better;   // sample beats the current extreme
  logic crossed;  // sample passes the threshold

  // strict compares keep the first occurrence of an equal peak
  assign better  = min_mode ? (sample < peak_value_q) : (sample > peak_value_q);
  assign crossed = min_mode ? (sample < threshold) : (sample > threshold);

  // peak tracking
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_q       <= 1'b0;
      peak_value_q <= 6'h00;
      peak_time_q  <= 8'h00;
    end else if (clear) begin
      seen_q       <= 1'b0;
      peak_value_q <= 6'h00;
      peak_time_q  <= 8'h00;
    end else if (sample_en && (!seen_q || better)) begin
      seen_q       <= 1'b1;
      peak_value_q <= sample;
      peak_time_q  <= sample_time;
    end
  end

  // threshold tracking, first crossing only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      threshold_met_q  <= 1'b0;
      threshold_time_q <= 8'h00;
    end else if (clear) begin
      threshold_met_q  <= 1'b0;
      threshold_time_q <= 8'h00;
    end else if (sample_en && !threshold_met_q && crossed) begin
      threshold_met_q  <= 1'b1;
      threshold_time_q <= sample_time;
    end
  end
endmodule : rfl_track

// ==== rtl/rfl_pulse_gen.sv ====
// test pulse generator for reflectometry
`timescale 1ns/1ps
module rfl_pulse_gen
  import rfl_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       launch,
  input  wire logic       fast_sel,
  input  wire logic [2:0] width,
  input  wire logic       step_tick,
  output logic            drive_pos_q,
  output logic            drive_neg_q
);
  logic [4:0] remain_q;   // ticks or cycles left in the pulse
  logic       fast_q;     // pulse in progress uses the fast transmitter
  logic       neg_next_q; // polarity of the next fast pulse
  logic       dec;        // one unit of pulse width elapsed
  logic [4:0] load;       // length of the pulse about to start

  // fast mode counts 8 ns sample ticks, link mode counts clock cycles
  assign dec = fast_q ? step_tick : 1'b1;

  // link pulses are only 50 or 100 ns long
  always_comb begin
    if (fast_sel) begin
      load = {2'b00, width};
    end else if (width == 3'h0) begin
      load = 5'h00;
    end else if (width == 3'h1) begin
      load = 5'(LINK_STEP_CYC);
    end else begin
      load = 5'(2 * LINK_STEP_CYC);
    end
  end

  // pulse timer and drive
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      remain_q    <= 5'h00;
      fast_q      <= 1'b0;
      neg_next_q  <= 1'b0;
      drive_pos_q <= 1'b0;
      drive_neg_q <= 1'b0;
    end else if (launch) begin
      remain_q    <= load;
      fast_q      <= fast_sel;
      // zero width drives nothing but capture still runs
      drive_pos_q <= (load != 5'h00) && !(fast_sel && neg_next_q);
      drive_neg_q <= (load != 5'h00) && fast_sel && neg_next_q;
      if (fast_sel && load != 5'h00) begin
        neg_next_q <= ~neg_next_q;
      end
    end else if (remain_q != 5'h00 && dec) begin
      remain_q <= remain_q - 5'h01;
      if (remain_q == 5'h01) begin
        drive_pos_q <= 1'b0;
        drive_neg_q <= 1'b0;
      end
    end
  end
endmodule : rfl_pulse_gen

// ==== rtl/rfl_capture.sv ====
// reflectometry capture top: registers, window timer and sequencing
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module rfl_capture
  import rfl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  addr,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [15:0] rd_data_q,
  input  wire logic        sample_valid,
  input  wire logic [5:0]  sample_data,
  output logic             drive_pos_q,
  output logic             drive_neg_q,
  output logic             tx_pair_sel_q,
  output logic             rx_pair_sel_q,
  output logic             busy_q
);
  import rfl_pkg::*;

  // control fields
  logic       fast_sel_q;     // use the fast transmitter
  logic [2:0] pulse_width_q;  // pulse width in steps when fast, else link length code
  logic       min_mode_q;     // 1 searches for the minimum
  logic [5:0] threshold_q;    // receive threshold
  logic       launch_pulse_q; // send bit, self clearing

  // window fields
  logic [7:0] window_start_q; // first monitored step
  logic [7:0] window_stop_q;  // last monitored step

  // sequencing
  rfl_state_t state_q;        // capture sequencer
  rfl_state_t state_d;
  logic [7:0] time_q;         // steps since launch
  logic       launch_go;      // one-cycle start of a capture
  logic       finish;         // last step processed
  logic       in_window;      // current step inside the window
  logic       sample_en;      // feed the tracker this cycle

  // results from the tracker
  logic [5:0] peak_value;
  logic [7:0] peak_time;
  logic       threshold_met;
  logic [7:0] threshold_time;

  // decoded writes
  logic wr_control;
  logic wr_window;

  assign wr_control = wr_en && (addr == ADDR_CONTROL);
  assign wr_window  = wr_en && (addr == ADDR_WINDOW);

  // a new capture starts only from idle, so a launch write never disturbs a busy run
  assign launch_go = wr_control && wr_data[CTL_LAUNCH_BIT] && (state_q == ST_IDLE);

  // window test on the current step
  assign in_window = (time_q >= window_start_q) && (time_q <= window_stop_q);

  // a stop below the start just gives an empty window
  assign finish = sample_valid && (time_q == window_stop_q);

  // only samples inside the window reach the tracker
  assign sample_en = (state_q == ST_CAPTURE) && sample_valid && in_window;

  // control register fields other than the send bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_sel_q    <= 1'b0;
      tx_pair_sel_q <= 1'b0;
      rx_pair_sel_q <= 1'b0;
      pulse_width_q <= WIDTH_RST;
      min_mode_q    <= 1'b0;
      threshold_q   <= THRESHOLD_RST;
    end else if (wr_control && state_q == ST_IDLE) begin
      // settings are frozen during a capture so results stay coherent
      fast_sel_q    <= wr_data[CTL_FAST_BIT];
      tx_pair_sel_q <= wr_data[CTL_TXCH_BIT];
      rx_pair_sel_q <= wr_data[CTL_RXCH_BIT];
      pulse_width_q <= wr_data[CTL_WIDTH_HI:CTL_WIDTH_LO];
      min_mode_q    <= wr_data[CTL_MIN_BIT];
      threshold_q   <= wr_data[CTL_THR_HI:0];
    end
  end

  // send bit: set by software, cleared by hardware at the end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      launch_pulse_q <= 1'b0;
    end else if (launch_go) begin
      launch_pulse_q <= 1'b1;
    end else if (state_q == ST_DONE) begin
      launch_pulse_q <= 1'b0;
    end
  end

  // window register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      window_start_q <= WIN_START_RST;
      window_stop_q  <= WIN_STOP_RST;
    end else if (wr_window) begin
      window_start_q <= wr_data[15:WIN_START_LO];
      window_stop_q  <= wr_data[WIN_START_LO-1:0];
    end
  end

  // next-state logic
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (launch_go) begin
          state_d = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        if (finish) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // step timer, one count per 8 ns sample
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      time_q <= 8'h00;
    end else if (launch_go) begin
      time_q <= 8'h00;
    end else if (state_q == ST_CAPTURE && sample_valid && !finish) begin
      time_q <= time_q + 8'h01;
    end
  end

  // busy flag mirrors the send bit for the outside world
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (launch_go) begin
      busy_q <= 1'b1;
    end else if (state_q == ST_DONE) begin
      busy_q <= 1'b0;
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= 16'h0000;
    end else if (rd_en) begin
      case (addr)
        ADDR_CONTROL: begin
          rd_data_q <= {1'b0, fast_sel_q, tx_pair_sel_q, rx_pair_sel_q,
                        launch_pulse_q, pulse_width_q, min_mode_q, 1'b0,
                        threshold_q};
        end
        ADDR_WINDOW: begin
          rd_data_q <= {window_start_q, window_stop_q};
        end
        ADDR_PEAK: begin
          // reserved upper bits read zero
          rd_data_q <= {2'b00, peak_value, peak_time};
        end
        ADDR_THRESHOLD: begin
          rd_data_q <= {7'h00, threshold_met, threshold_time};
        end
        default: begin
          // unmapped addresses read zero
          rd_data_q <= 16'h0000;
        end
      endcase
    end
  end

  // peak and threshold tracker, cleared at every launch
  rfl_track u_track (
    .sys_clk          (sys_clk),
    .rst_n            (rst_n),
    .clear            (launch_go),
    .sample_en        (sample_en),
    .sample           (sample_data),
    .sample_time      (time_q),
    .min_mode         (min_mode_q),
    .threshold        (threshold_q),
    .peak_value_q     (peak_value),
    .peak_time_q      (peak_time),
    .threshold_met_q  (threshold_met),
    .threshold_time_q (threshold_time)
  );

  // test pulse source, started with the capture; the launch write carries the
  // settings for this very pulse, so they are taken from the bus, not from the
  // registers that only load at the same edge
  rfl_pulse_gen u_pulse (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .launch      (launch_go),
    .fast_sel    (wr_data[CTL_FAST_BIT]),
    .width       (wr_data[CTL_WIDTH_HI:CTL_WIDTH_LO]),
    .step_tick   (sample_valid),
    .drive_pos_q (drive_pos_q),
    .drive_neg_q (drive_neg_q)
  );
endmodule : rfl_capture

// ==== dv/rfl_capture_props.sv ====
// port assertions for the reflectometry capture block
`timescale 1ns/1ps
module rfl_capture_props
  import rfl_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [4:0]  addr,
  input wire logic [15:0] wr_data,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [15:0] rd_data_q,
  input wire logic        drive_pos_q,
  input wire logic        drive_neg_q,
  input wire logic        tx_pair_sel_q,
  input wire logic        rx_pair_sel_q,
  input wire logic        busy_q
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // read data must not wander between reads
  a_rd_data_hold: assert property (!rd_en |=> $stable(rd_data_q))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rd_en && (addr < ADDR_CONTROL || addr > ADDR_THRESHOLD)
    |=> rd_data_q == 16'h0000) else $error("unmapped read not zero");
  a_peak_rsvd: assert property (rd_en && addr == ADDR_PEAK |=> rd_data_q[15:14] == 2'h0)
    else $error("peak reserved bits set");
  a_thr_rsvd: assert property (rd_en && addr == ADDR_THRESHOLD |=> rd_data_q[15:9] == 7'h00)
    else $error("threshold reserved bits set");
  // an idle launch write arms the capture at once
  a_launch_busy: assert property (wr_en && addr == ADDR_CONTROL && wr_data[11] && !busy_q
    |=> busy_q) else $error("launch did not start capture");
  a_send_bit_busy: assert property (rd_en && addr == ADDR_CONTROL
    |=> rd_data_q[11] == $past(busy_q)) else $error("send bit differs from busy");
  a_drive_excl: assert property (!(drive_pos_q && drive_neg_q))
    else $error("both pulse drives high");
  // control writes during a capture are dropped, so pair selects hold
  a_pair_frozen: assert property (busy_q && wr_en && addr == ADDR_CONTROL
    |=> $stable(tx_pair_sel_q) && $stable(rx_pair_sel_q)) else $error("pair select changed");
endmodule : rfl_capture_props
bind rfl_capture rfl_capture_props u_props (.sys_clk, .rst_n, .addr, .wr_data, .wr_en, .rd_en,
  .rd_data_q, .drive_pos_q, .drive_neg_q, .tx_pair_sel_q, .rx_pair_sel_q, .busy_q);

// ==== dv/rfl_cable_model.sv ====
// cable under test: answers each capture with a stream of reflected samples
`timescale 1ns/1ps
module rfl_cable_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       busy,
  input  wire logic       slow,
  input  wire logic       drv_pos,
  input  wire logic       drv_neg,
  output logic            sample_valid,
  output logic      [5:0] sample_data
);
  logic [5:0] wave [256]; // level per step, loaded by the bench
  logic [7:0] step_q;     // step count since the capture began
  logic [1:0] cnt_q;      // cycles between steps
  logic       busy_d;
  logic       pos_seen;   // polarity seen during this capture
  logic       neg_seen;
  // one step every 2 or 4 cycles; the line toggles when no sample stands
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {step_q, cnt_q, busy_d, pos_seen, neg_seen, sample_valid} <= '0;
      sample_data <= 6'h15;
    end else begin
      busy_d <= busy;
      sample_valid <= 1'b0;
      sample_data <= ~sample_data;
      // clear first so a drive on the launch edge still counts
      if (busy && !busy_d) begin
        pos_seen <= 1'b0;
        neg_seen <= 1'b0;
      end
      if (drv_pos) pos_seen <= 1'b1;
      if (drv_neg) neg_seen <= 1'b1;
      if (!busy) begin
        step_q <= 8'h00;
        cnt_q <= 2'h0;
      end else if (cnt_q == {slow, 1'b1}) begin
        sample_valid <= 1'b1;
        sample_data <= wave[step_q];
        step_q <= step_q + 8'h01;
        cnt_q <= 2'h0;
      end else begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end
endmodule : rfl_cable_model

// ==== dv/tb.sv ====
// self-checking bench for the reflectometry capture block
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module tb;
  import rfl_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        slow = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [15:0] wr_data = 16'h0000;
  logic [15:0] rd_data_q, rv;
  logic        sample_valid, drive_pos_q, drive_neg_q, tx_pair_sel_q, rx_pair_sel_q, busy_q;
  logic [5:0]  sample_data;
  int          num_errors = 0;
  int          check_count = 0;
  logic        fast_neg = 1'b0; // next fast pulse polarity
  always #12.5 sys_clk = ~sys_clk;
  rfl_capture u_dut (.sys_clk, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data_q,
    .sample_valid, .sample_data, .drive_pos_q, .drive_neg_q, .tx_pair_sel_q,
    .rx_pair_sel_q, .busy_q);
  rfl_cable_model u_cab (.sys_clk, .rst_n, .busy(busy_q), .slow, .drv_pos(drive_pos_q),
    .drv_neg(drive_neg_q), .sample_valid, .sample_data);
  // one-cycle write strobe
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr
  // data are sampled in the cycle after the strobe and hold until the next read
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 d = rd_data_q;
  endtask : rd
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // expected {peak reg, threshold reg} for the loaded wave
  function automatic logic [31:0] predict(input logic [7:0] st, sp, input logic mn,
                                          input logic [5:0] th);
    logic [5:0] s, pv;
    logic [7:0] pt, tt;
    logic       met, any;
    {pv, pt, tt, met, any} = '0;
    for (int t = st; t <= sp; t++) begin
      s = u_cab.wave[t];
      if (!any || (mn ? s < pv : s > pv)) begin
        pv = s;
        pt = t[7:0];
      end
      any = 1'b1;
      if (!met && (mn ? s < th : s > th)) begin
        met = 1'b1;
        tt = t[7:0];
      end
    end
    return {2'h0, pv, pt, 7'h00, met, tt};
  endfunction : predict
  initial begin
    logic [7:0]  st, sp;
    logic        mn, fst, tx, rx;
    logic [2:0]  w;
    logic [5:0]  th;
    logic [31:0] ex;
    int          n;
    void'($urandom(32'h69C1));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(ADDR_CONTROL, rv); `CHK(rv, 16'h0020)
    rd(ADDR_WINDOW, rv); `CHK(rv, 16'h00FF)
    rd(ADDR_PEAK, rv); `CHK(rv, 16'h0000)
    wr(ADDR_THRESHOLD, 16'hFFFF);
    rd(ADDR_THRESHOLD, rv); `CHK(rv, 16'h0000)
    rd(5'h1F, rv); `CHK(rv, 16'h0000)
    for (int i = 0; i < 40; i++) begin
      st = 8'($urandom_range(0, 30));
      sp = st + 8'($urandom_range(0, 30));
      {mn, fst, tx, rx, w, th} = 13'($urandom);
      slow <= 1'($urandom);
      for (int t = 0; t < 256; t++) u_cab.wave[t] = 6'($urandom);
      // flat line at the midpoint: first time kept, strict threshold unmet
      if (i < 2) begin
        for (int t = 0; t < 256; t++) u_cab.wave[t] = 6'h20;
        th = 6'h20;
        mn = i[0];
      end
      if (i == 2) {st, sp} = 16'h0500; // stop before start
      if (i == 3) {st, sp} = 16'h00FF; // widest window
      wr(ADDR_WINDOW, {st, sp});
      rd(ADDR_WINDOW, rv); `CHK(rv, {st, sp})
      wr(ADDR_CONTROL, {1'b0, fst, tx, rx, 1'b1, w, mn, 1'b0, th});
      rd(ADDR_CONTROL, rv); `CHK(rv[11], 1'b1)
      wr(ADDR_CONTROL, 16'h0000); // dropped while busy
      n = 0;
      while (busy_q !== 1'b0 && n < 3000) begin
        @(posedge sys_clk);
        n++;
      end
      if (n == 3000) begin
        num_errors++;
        break;
      end
      repeat (8) @(posedge sys_clk);
      ex = predict(st, sp, mn, th);
      rd(ADDR_PEAK, rv); `CHK(rv, ex[31:16])
      rd(ADDR_THRESHOLD, rv); `CHK(rv[15:8], ex[15:8])
      if (ex[8]) `CHK(rv[7:0], ex[7:0])
      rd(ADDR_CONTROL, rv); `CHK(rv, {1'b0, fst, tx, rx, 1'b0, w, mn, 1'b0, th})
      `CHK({tx_pair_sel_q, rx_pair_sel_q}, {tx, rx})
      `CHK({u_cab.pos_seen, u_cab.neg_seen}, w == 3'h0 ? 2'b00 : fst && fast_neg ? 2'b01 : 2'b10)
      if (fst && w != 3'h0) fast_neg = ~fast_neg;
    end
    wrap_up();
  end
endmodule : tb
